// ==== testbench/dswc_top_asserts.sv ====
// Port assertions for the deep sleep wake control block.
module dswc_top_asserts (
   input wire        CLK_SYS,
   input wire        RSTN,
   input wire [31:0] PRDATA,
   input wire        POWER_SAVE_INSTR,
   input wire        POWER_SAVE_INSTR_OPERAND_ZERO,
   input wire        TRUE_POWER_ON,
   input wire        WATCHDOG_TIMEOUT,
   input wire        BROWNOUT_EVENT,
   input wire [15:0] PIN_OUT,
   input wire [15:0] PIN_OE,
   input wire        DEEP_SLEEP,
   input wire        SLEEP,
   input wire        POR_REARM
);
   default clocking dcb @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   sequence s_enter;
      POWER_SAVE_INSTR && POWER_SAVE_INSTR_OPERAND_ZERO && !DEEP_SLEEP && !SLEEP && !TRUE_POWER_ON;
   endsequence
   sequence s_asleep;
      ##[1:3] (DEEP_SLEEP || SLEEP);
   endsequence
   a_sleep_exclusive: assert property (!(DEEP_SLEEP && SLEEP))
      else $error("deep and ordinary sleep together");
   a_enter_sleep: assert property (s_enter |-> s_asleep)
      else $error("power save instruction ignored");
   a_brown_rearm: assert property (DEEP_SLEEP && BROWNOUT_EVENT |-> POR_REARM)
      else $error("brown-out did not re-arm power-on");
   a_rearm_only_deep: assert property (!DEEP_SLEEP |-> !POR_REARM)
      else $error("re-arm outside deep sleep");
   a_wdt_wakes: assert property (DEEP_SLEEP && WATCHDOG_TIMEOUT |-> ##[1:4] !DEEP_SLEEP)
      else $error("watchdog did not wake");
   a_pins_frozen: assert property ($past(DEEP_SLEEP) && DEEP_SLEEP |-> $stable(PIN_OUT) && $stable(PIN_OE))
      else $error("pins moved in deep sleep");
   a_upper_zero: assert property (PRDATA[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   a_power_on_run: assert property (TRUE_POWER_ON && !DEEP_SLEEP |=> !SLEEP && !DEEP_SLEEP)
      else $error("power-on left a sleep state");
endmodule // dswc_top_asserts
bind dswc_top dswc_top_asserts dswc_top_asserts_i (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .PRDATA(PRDATA),
   .POWER_SAVE_INSTR(POWER_SAVE_INSTR), .POWER_SAVE_INSTR_OPERAND_ZERO(POWER_SAVE_INSTR_OPERAND_ZERO), .TRUE_POWER_ON(TRUE_POWER_ON),
   .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT), .BROWNOUT_EVENT(BROWNOUT_EVENT), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
   .DEEP_SLEEP(DEEP_SLEEP), .SLEEP(SLEEP), .POR_REARM(POR_REARM));

// ==== testbench/tb_dswc_top.sv ====
// Self-checking bench for the deep sleep wake control block.
`include "dswc_defines.vh"
module tb_dswc_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, rstn, psel, pen, pwr, power_save_instr, tpor, pdone, spor, brown, sense, opz;
   logic [11:0] pa;
   logic [31:0] pwd, rdat;
   logic [15:0] dir;
   logic [4:0]  src;
   logic [15:0] lat;
   logic [15:0] wexp [5] = '{16'h0100, 16'h0080, 16'h0010, 16'h0008, 16'h0004};
   wire  [31:0] prd;
   wire  [15:0] pout, poe;
   wire         prdy, deep, slp, rearm, sink;
   int          bad_count, samples_checked, i;
   dswc_top dswc_top_i (.CLK_SYS(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
      .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(), .POWER_SAVE_INSTR(power_save_instr),
      .POWER_SAVE_INSTR_OPERAND_ZERO(opz), .TRUE_POWER_ON(tpor), .POR_SEQ_DONE(pdone), .SUPPLY_POR_EVENT(spor),
      .EXT_INTERRUPT_PIN(src[0]), .MASTER_CLEAR_PIN_N(~src[4]), .SLEEP_FAULT(src[1]),
      .WATCHDOG_TIMEOUT(src[2]), .CALENDAR_ALARM(src[3]), .BROWNOUT_EVENT(brown),
      .DISCHARGE_SENSE_PIN(sense), .PIN_DIRECTION_BITS(dir), .OUTPUT_LATCH_BITS(lat), .PIN_OUT(pout),
      .PIN_OE(poe), .DEEP_SLEEP(deep), .SLEEP(slp), .POR_REARM(rearm), .DISCHARGE_SINK_ON(sink));
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (prdy !== 1'b1 && n < 16);
      rdat = prd;
      psel <= 1'b0;
      pen <= 1'b0;
      if (prdy !== 1'b1) begin
         bad_count++;
         print_verdict();
      end
   endtask
   // Read data is taken at the edge at which ready is seen high.
   task automatic rd(input logic [11:0] a, input logic [15:0] e, input string nm, input logic [15:0] m = 16'hffff);
      apb(1'b0, a, 32'h0);
      chk(nm, {16'h0, e}, rdat & {16'h0, m});
   endtask
   task automatic wt(input logic sel, input logic e);
      int n;
      n = 0;
      while ((sel ? slp : deep) !== e && n < 40) begin
         @(posedge clk);
         n++;
      end
      chk(sel ? "sleep" : "deep_sleep", {31'h0, e}, {31'h0, sel ? slp : deep});
      if (n == 40) print_verdict();
   endtask
   task automatic arm(input logic [15:0] c);
      apb(1'b1, `DSWC_OFF_KEY, {24'h0, `DSWC_KEY1});
      apb(1'b1, `DSWC_OFF_KEY, {24'h0, `DSWC_KEY2});
      apb(1'b1, `DSWC_OFF_CTRL, {16'h0, c});
      @(posedge clk);
      power_save_instr <= 1'b1;
      @(posedge clk);
      power_save_instr <= 1'b0;
   endtask
   task automatic por_done();
      repeat (5) @(posedge clk);
      src <= 5'h00;
      repeat (4) @(posedge clk);
      pdone <= 1'b1;
      @(posedge clk);
      pdone <= 1'b0;
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      {rstn, psel, pen, pwr, power_save_instr, tpor, pdone, spor, brown, src, pa, pwd} = '0;
      sense = 1'b1;
      opz = 1'b1;
      dir = 16'h0000;
      rdat = 32'h0;
      lat = 16'h1234;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      rd(`DSWC_OFF_CTRL, 16'h0000, "ctrl_reset");
      spor <= 1'b1;
      repeat (4) @(posedge clk);
      spor <= 1'b0;
      rd(`DSWC_OFF_WAKE, 16'h0001, "wake_supply_por");
      apb(1'b1, `DSWC_OFF_CTRL, 32'h8000);
      rd(`DSWC_OFF_CTRL, 16'h0000, "arm_without_key");
      $display("test reset_and_key done");
      for (i = 0; i < 5; i++) begin
         lat <= 16'h1234;
         dir <= 16'h00ff;
         arm(16'h8000);
         wt(0, 1);
         brown <= (i == 0);
         lat <= 16'habcd;
         dir <= 16'h0f0f;
         @(posedge clk);
         chk("por_rearm", {31'h0, i == 0}, {31'h0, rearm});
         brown <= 1'b0;
         wt(0, 1);
         src <= 5'h01 << i;
         wt(0, 0);
         src <= 5'h08 | (5'h01 << i);
         por_done();
         rd(`DSWC_OFF_WAKE, wexp[i], "wake_source");
         rd(`DSWC_OFF_CTRL, (i == 0) ? 16'h0003 : 16'h0001, "ctrl_after_wake");
         rd(`DSWC_OFF_RSTCTL, 16'h0400, "exit_flag", 16'h0400);
         chk("pins_held", 32'h1234, {16'h0, pout});
         chk("pin_enable_held", 32'hff00, {16'h0, poe});
         apb(1'b1, `DSWC_OFF_RSTCTL, 32'h0);
         apb(1'b1, `DSWC_OFF_CTRL, 32'h0);
         repeat (2) @(posedge clk);
         chk("pins_released", 32'habcd, {16'h0, pout});
         chk("pin_enable", 32'hf0f0, {16'h0, poe});
      end
      rd(`DSWC_OFF_RSTCTL, 16'h0000, "exit_cleared", 16'h0400);
      $display("test wake_sources done");
      apb(1'b1, `DSWC_OFF_DISCH, 32'h8000);
      arm(16'h8104);
      src <= 5'h08;
      sense <= 1'b0;
      repeat (8) @(posedge clk);
      wt(0, 1);
      sense <= 1'b1;
      src <= 5'h04;
      wt(0, 0);
      por_done();
      apb(1'b1, `DSWC_OFF_CTRL, 32'h0);
      apb(1'b1, `DSWC_OFF_DISCH, 32'hffff);
      rd(`DSWC_OFF_DISCH, 16'h8100, "disch_ctrl");
      chk("sink_on", 32'h1, {31'h0, sink});
      opz <= 1'b0;
      @(posedge clk);
      power_save_instr <= 1'b1;
      @(posedge clk);
      power_save_instr <= 1'b0;
      repeat (3) @(posedge clk);
      chk("operand_nonzero", 32'h0, {31'h0, slp});
      opz <= 1'b1;
      @(posedge clk);
      power_save_instr <= 1'b1;
      @(posedge clk);
      power_save_instr <= 1'b0;
      wt(1, 1);
      chk("not_deep", 32'h0, {31'h0, deep});
      sense <= 1'b0;
      wt(1, 0);
      sense <= 1'b1;
      rd(`DSWC_OFF_INTFLAG, 16'h0001, "disch_irq");
      $display("test sleep_modes done");
      apb(1'b1, `DSWC_OFF_CTRL, 32'h0104);
      tpor <= 1'b1;
      repeat (2) @(posedge clk);
      tpor <= 1'b0;
      rd(`DSWC_OFF_CTRL, 16'h0000, "ctrl_por");
      rd(`DSWC_OFF_DISCH, 16'h0000, "disch_por");
      rd(`DSWC_OFF_WAKE, 16'h0001, "wake_por");
      rd(`DSWC_OFF_RSTCTL, 16'h0001, "rst_por");
      $display("test power_on done");
      print_verdict();
   end
endmodule // tb_dswc_top

// ==== verilog/dswc_defines.vh ====
// Register offsets, bit positions, reset values and key codes for the deep sleep wake control block.
`ifndef DSWC_DEFINES_VH
`define DSWC_DEFINES_VH
`define DSWC_OFF_CTRL       12'h000
`define DSWC_OFF_WAKE       12'h004
`define DSWC_OFF_RSTCTL     12'h008
`define DSWC_OFF_DISCH      12'h00c
`define DSWC_OFF_INTFLAG    12'h010
`define DSWC_OFF_KEY        12'h014
`define DSWC_CTRL_ARM       15
`define DSWC_CTRL_CALDIS    8
`define DSWC_CTRL_DISDIS    2
`define DSWC_CTRL_BOR       1
`define DSWC_CTRL_HOLD      0
`define DSWC_WAKE_EXT       8
`define DSWC_WAKE_FLT       7
`define DSWC_WAKE_WDT       4
`define DSWC_WAKE_ALM       3
`define DSWC_WAKE_MASTER_CLEAR_PIN      2
`define DSWC_WAKE_POR       0
`define DSWC_RST_EXIT       10
`define DSWC_RST_POR        0
`define DSWC_DIS_EN         15
`define DSWC_DIS_SINK       8
`define DSWC_IF_DISCH       0
`define DSWC_KEY1           8'h55
`define DSWC_KEY2           8'haa
`define DSWC_ZERO16         16'h0000
`endif

// ==== verilog/dswc_top.v ====
// Deep sleep arming, wake source capture, pin hold and slow discharge wake logic.
// Summary of operation
// - Exit flag sets on deep sleep entry.
// - True power-on outside deep sleep resets all deep sleep state.
// - Arm bit selects deep or ordinary sleep.
// - Wake clears the arm bit automatically.
// - Calendar wake disable bit blocks alarm wakes.
// - Discharge wake disable blocks detector deep wakes.
// - Brown-out flag records deep sleep brown-out.
// - Brown-out never wakes; in deep sleep it re-arms power-on and sets the brown-out flag.
// - Hold bit freezes pins until software clears.
// - Control bits other than arm survive the deep sleep exit.
// - Setting arm bit clears wake source register.
// - External pin and master clear wake flags.
// - Fault during deep sleep sets fault flag.
// - Watchdog and alarm wake flags.
// - Power-on flag may set outside deep sleep.
// - Wake bits survive exit; true power-on clears all but the power-on bit.
// - Detector wakes ordinary sleep below input-low threshold.
// - Detector wake sets interrupt flag bit zero.
// - Wakes during power-on sequence are ignored.
// - Discharge control holds enable and sink bits.
`include "dswc_defines.vh"
module dswc_top (
   input  wire        CLK_SYS,
   input  wire        RSTN,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [11:0] PADDR,
   input  wire [31:0] PWDATA,
   output wire [31:0] PRDATA,
   output wire        PREADY,
   output wire        PSLVERR,
   input  wire        POWER_SAVE_INSTR,
   input  wire        POWER_SAVE_INSTR_OPERAND_ZERO,
   input  wire        TRUE_POWER_ON,
   input  wire        POR_SEQ_DONE,
   input  wire        SUPPLY_POR_EVENT,
   input  wire        EXT_INTERRUPT_PIN,
   input  wire        MASTER_CLEAR_PIN_N,
   input  wire        SLEEP_FAULT,
   input  wire        WATCHDOG_TIMEOUT,
   input  wire        CALENDAR_ALARM,
   input  wire        BROWNOUT_EVENT,
   input  wire        DISCHARGE_SENSE_PIN,
   input  wire [15:0] PIN_DIRECTION_BITS,
   input  wire [15:0] OUTPUT_LATCH_BITS,
   output reg  [15:0] PIN_OUT,
   output reg  [15:0] PIN_OE,
   output wire        DEEP_SLEEP,
   output wire        SLEEP,
   output wire        POR_REARM,
   output wire        DISCHARGE_SINK_ON
);
   localparam [3:0] ST_RUN   = 4'b0001;
   localparam [3:0] ST_SLEEP = 4'b0010;
   localparam [3:0] ST_DEEP  = 4'b0100;
   localparam [3:0] ST_PORS  = 4'b1000;

   reg  [3:0]  state_ff;
   reg  [3:0]  nxt_state;
   reg         arm_ff, caldis_ff, disdis_ff, bor_ff, hold_ff;
   reg  [15:0] wake_ff;
   reg         exit_ff, por_flag_ff;
   reg         dis_en_ff, dis_sink_ff, disch_if_ff;
   reg  [1:0]  key_ff;
   reg  [15:0] frz_out_ff, frz_oe_ff;
   reg  [31:0] prdata_ff;
   reg         rd_busy_ff;
   reg  [2:0]  ext_s_ff, master_clear_pin_s_ff, sense_s_ff;

   wire wr = PSEL & PENABLE & PWRITE;
   wire rd = PSEL & PENABLE & ~PWRITE;
   wire ext_q   = ext_s_ff[1] & ext_s_ff[2];
   wire master_clear_pin_q  = ~master_clear_pin_s_ff[1] & ~master_clear_pin_s_ff[2];
   wire sense_lo = ~sense_s_ff[1] & ~sense_s_ff[2];
   wire in_deep = state_ff == ST_DEEP;
   wire detector_trip = dis_en_ff & sense_lo;
   wire alarm_ok = CALENDAR_ALARM & ~caldis_ff;
   wire dis_ok = detector_trip & ~disdis_ff;
   // Brown-out is left out of the wake term on purpose.
   wire deep_wake = in_deep & (ext_q | master_clear_pin_q | SLEEP_FAULT | WATCHDOG_TIMEOUT | alarm_ok | dis_ok
                    | SUPPLY_POR_EVENT);
   wire key_ok = key_ff == 2'b10;
   wire wr_ctrl = wr & (PADDR == `DSWC_OFF_CTRL);
   wire arm_set = wr_ctrl & PWDATA[`DSWC_CTRL_ARM] & key_ok & ~arm_ff;
   wire enter = POWER_SAVE_INSTR & POWER_SAVE_INSTR_OPERAND_ZERO & (state_ff == ST_RUN);
   wire enter_deep = enter & arm_ff;

   // Reads take one wait state so that the registered read data already stands at the ready edge.
   assign PREADY = ~rd | rd_busy_ff;
   assign PSLVERR = 1'b0;
   assign PRDATA = prdata_ff;
   assign DEEP_SLEEP = in_deep;
   assign SLEEP = state_ff == ST_SLEEP;
   assign POR_REARM = in_deep & BROWNOUT_EVENT;
   assign DISCHARGE_SINK_ON = dis_en_ff & dis_sink_ff;

   always @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         ext_s_ff <= 3'h0;
         master_clear_pin_s_ff <= 3'h7;
         sense_s_ff <= 3'h7;
      end else begin
         ext_s_ff <= {ext_s_ff[1:0], EXT_INTERRUPT_PIN};
         master_clear_pin_s_ff <= {master_clear_pin_s_ff[1:0], MASTER_CLEAR_PIN_N};
         sense_s_ff <= {sense_s_ff[1:0], DISCHARGE_SENSE_PIN};
      end
   end

   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_RUN:   if (enter) nxt_state = arm_ff ? ST_DEEP : ST_SLEEP;
         ST_SLEEP: if (detector_trip | ext_q) nxt_state = ST_RUN;
         ST_DEEP:  if (deep_wake) nxt_state = ST_PORS;
         ST_PORS:  if (POR_SEQ_DONE) nxt_state = ST_RUN;
         default:  nxt_state = ST_RUN;
      endcase
   end

   // Retained state is cleared by RSTN and by the true power-on input outside deep sleep.
   always @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         state_ff <= ST_RUN;
         arm_ff <= 1'b0;
         caldis_ff <= 1'b0;
         disdis_ff <= 1'b0;
         bor_ff <= 1'b0;
         hold_ff <= 1'b0;
         wake_ff <= `DSWC_ZERO16;
         exit_ff <= 1'b0;
         por_flag_ff <= 1'b0;
         dis_en_ff <= 1'b0;
         dis_sink_ff <= 1'b0;
         disch_if_ff <= 1'b0;
         key_ff <= 2'b00;
         frz_out_ff <= `DSWC_ZERO16;
         frz_oe_ff <= `DSWC_ZERO16;
      end else if (TRUE_POWER_ON && !in_deep) begin
         state_ff <= ST_RUN;
         arm_ff <= 1'b0;
         caldis_ff <= 1'b0;
         disdis_ff <= 1'b0;
         bor_ff <= 1'b0;
         hold_ff <= 1'b0;
         wake_ff <= `DSWC_ZERO16;
         wake_ff[`DSWC_WAKE_POR] <= 1'b1;
         exit_ff <= 1'b0;
         por_flag_ff <= 1'b1;
         dis_en_ff <= 1'b0;
         dis_sink_ff <= 1'b0;
         disch_if_ff <= 1'b0;
         key_ff <= 2'b00;
         frz_out_ff <= `DSWC_ZERO16;
         frz_oe_ff <= `DSWC_ZERO16;
      end else begin
         state_ff <= nxt_state;
         if (wr && PADDR == `DSWC_OFF_KEY) begin
            if (PWDATA[7:0] == `DSWC_KEY1)
               key_ff <= 2'b01;
            else if (PWDATA[7:0] == `DSWC_KEY2 && key_ff == 2'b01)
               key_ff <= 2'b10;
            else
               key_ff <= 2'b00;
         end else if (wr) begin
            key_ff <= 2'b00;
         end
         if (wr_ctrl) begin
            caldis_ff <= PWDATA[`DSWC_CTRL_CALDIS];
            disdis_ff <= PWDATA[`DSWC_CTRL_DISDIS];
            bor_ff <= PWDATA[`DSWC_CTRL_BOR];
            if (!PWDATA[`DSWC_CTRL_ARM])
               arm_ff <= 1'b0;
            else if (arm_set)
               arm_ff <= 1'b1;
            if (!PWDATA[`DSWC_CTRL_HOLD])
               hold_ff <= 1'b0;
         end
         if (in_deep && BROWNOUT_EVENT)
            bor_ff <= 1'b1;
         if (enter_deep) begin
            hold_ff <= 1'b1;
            exit_ff <= 1'b1;
            frz_out_ff <= OUTPUT_LATCH_BITS;
            frz_oe_ff <= ~PIN_DIRECTION_BITS;
         end
         if (in_deep && deep_wake)
            arm_ff <= 1'b0;
         if (wr && PADDR == `DSWC_OFF_WAKE)
            wake_ff <= PWDATA[15:0] & 16'h019d;
         if (arm_set)
            wake_ff <= `DSWC_ZERO16;
         if (in_deep) begin
            if (ext_q) wake_ff[`DSWC_WAKE_EXT] <= 1'b1;
            if (master_clear_pin_q) wake_ff[`DSWC_WAKE_MASTER_CLEAR_PIN] <= 1'b1;
            if (SLEEP_FAULT) wake_ff[`DSWC_WAKE_FLT] <= 1'b1;
            if (WATCHDOG_TIMEOUT) wake_ff[`DSWC_WAKE_WDT] <= 1'b1;
            if (alarm_ok) wake_ff[`DSWC_WAKE_ALM] <= 1'b1;
         end
         if (SUPPLY_POR_EVENT && state_ff != ST_PORS)
            wake_ff[`DSWC_WAKE_POR] <= 1'b1;
         if (wr && PADDR == `DSWC_OFF_RSTCTL) begin
            if (!PWDATA[`DSWC_RST_EXIT] && !enter_deep) exit_ff <= 1'b0;
            if (!PWDATA[`DSWC_RST_POR]) por_flag_ff <= 1'b0;
         end
         if (in_deep && deep_wake)
            por_flag_ff <= 1'b1;
         if (wr && PADDR == `DSWC_OFF_DISCH) begin
            dis_en_ff <= PWDATA[`DSWC_DIS_EN];
            dis_sink_ff <= PWDATA[`DSWC_DIS_SINK];
         end
         if (wr && PADDR == `DSWC_OFF_INTFLAG && !PWDATA[`DSWC_IF_DISCH])
            disch_if_ff <= 1'b0;
         if (detector_trip && (state_ff == ST_SLEEP || dis_ok))
            disch_if_ff <= 1'b1;
      end
   end

   always @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         PIN_OUT <= `DSWC_ZERO16;
         PIN_OE <= `DSWC_ZERO16;
      end else if (hold_ff) begin
         PIN_OUT <= frz_out_ff;
         PIN_OE <= frz_oe_ff;
      end else begin
         PIN_OUT <= OUTPUT_LATCH_BITS;
         PIN_OE <= ~PIN_DIRECTION_BITS;
      end
   end

   always @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         rd_busy_ff <= 1'b0;
      end else begin
         rd_busy_ff <= rd & ~rd_busy_ff;
      end
   end

   always @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         prdata_ff <= 32'h0;
      end else if (rd && !rd_busy_ff) begin
         if (PADDR == `DSWC_OFF_CTRL)
            prdata_ff <= {16'h0, arm_ff, 6'h0, caldis_ff, 5'h0, disdis_ff, bor_ff, hold_ff};
         else if (PADDR == `DSWC_OFF_WAKE)
            prdata_ff <= {16'h0, wake_ff};
         else if (PADDR == `DSWC_OFF_RSTCTL)
            prdata_ff <= {21'h0, exit_ff, 9'h0, por_flag_ff};
         else if (PADDR == `DSWC_OFF_DISCH)
            prdata_ff <= {16'h0, dis_en_ff, 6'h0, dis_sink_ff, 8'h0};
         else if (PADDR == `DSWC_OFF_INTFLAG)
            prdata_ff <= {31'h0, disch_if_ff};
         else
            prdata_ff <= 32'h0;
      end
   end
endmodule // dswc_top
